// ### logic/lintc_top.sv
`timescale 1ns/1ps
// Operation
// [R1] Receive output follows bus level: low dominant, high recessive.
// [R2] Select high: enable high gives Operation, low gives Transmitter Off.
// [R3] Floating select counts as low; transmitter stays off.
// [R4] Select high during Power-Down wakes the transceiver.
// [R5] Transmitting: bus dominant while transmit low, recessive while high.
// [R6] Floating transmit input counts as high; bus stays recessive.
// [R7] Reset output high only while regulator supply is valid.
// [R8] Enable line low, from any source, forces Transmitter Off.
// [R9] Select high: transmit versus bus mismatch reported on fault line, debounced.
// [R10] Mismatch fault valid only after settling time following transmit edge.
// [R11] Enable line sampled at intervals shorter than ten microseconds.
// [R12] Transmit low but bus high drives the fault line low.
// [R13] Select high and thermal shutdown drive the fault line low.
// [R14] External low on enable line is not reported as fault.
// [R15] After wake with select low, fault line shows wake source.
// [R16] Thermal overload shuts transmitter and regulator until cooled.
// [R17] Host tells contention from thermal overload by driving transmit, reading receive.
// [R18] Bus dominant beyond timeout disables the transmitter.
// [R19] Timeout forces receive high, fault low, pull-up off together.
// [R20] Timeout timer restarts on recessive bus or power-on reset.
// [R21] Host must not tie select permanently high.
// [R22] Enter Operation only with supply, select, enable, transmit all high.
// [R23] Select low leaves Operation to Power-Down; enable low to Transmitter Off.
// [R24] Remote wake: bus low for least wake time, then rising.
// [R25] Internal fault keeps transmitter off despite external high enable.
// [R26] All timers run on one timebase and clear in power-on reset.
module lintc_top #(
  parameter int TICK_CYCLES = lintc_pkg::TICK_CYCLES,
  parameter int DOM_TIMEOUT_TICKS = lintc_pkg::DOM_TIMEOUT_TICKS,
  parameter int SETTLE_TICKS = lintc_pkg::SETTLE_TICKS,
  parameter int WAKE_LOW_TICKS = lintc_pkg::WAKE_LOW_TICKS,
  parameter int SAMPLE_TICKS = lintc_pkg::SAMPLE_TICKS
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic battery_supply_ok,
  input wire logic regulator_output_ok,
  input wire logic thermal_overload,
  input wire logic select_local_wake,
  input wire logic select_floating,
  input wire logic tx_data,
  input wire logic tx_floating,
  input wire logic fault_tx_enable_in,
  output logic fault_tx_enable_out,
  output logic fault_tx_enable_oe,
  input wire logic lin_bus_line_in,
  output logic lin_bus_line_out,
  output logic lin_bus_line_oe,
  output logic lin_pull_up_en,
  output logic rx_data,
  output logic reset_out_n,
  output logic regulator_en,
  output lintc_pkg::lintc_mode_t mode,
  output logic status_valid,
  input wire logic status_ready,
  output logic [lintc_pkg::STATUS_W-1:0] status_data
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin conditioning

  lintc_pkg::lintc_state_t st_reg;
  lintc_pkg::lintc_state_t st_next;
  logic cs;
  logic txd;
  logic tick;
  logic in_por;
  logic rx_on;
  logic settled;
  logic dom_exp;
  logic wake_exp;
  logic samp_exp;
  logic lin_wake;
  logic mismatch;
  logic int_fault;
  logic go_op;
  logic fault_drive;
  logic [lintc_pkg::STATUS_W-1:0] word;

  assign cs = select_local_wake && !select_floating; // [R3]
  assign txd = tx_data || tx_floating; // [R6]
  assign tick = (st_reg.tick_cnt == lintc_pkg::CNT_W'(TICK_CYCLES - 1)); // [R26]
  assign in_por = (st_reg.mode == lintc_pkg::mode_por);
  assign rx_on = (st_reg.mode == lintc_pkg::mode_ready) ||
                 (st_reg.mode == lintc_pkg::mode_operation) ||
                 (st_reg.mode == lintc_pkg::mode_tx_off);

  ////////////////////////////////////////////////////////////////////////////////
  // Timers

  // Restarted on every transmit edge, so a rising edge also masks bus delay
  lintc_timer #(.W(lintc_pkg::CNT_W), .LIMIT(SETTLE_TICKS)) u_settle (
    .clk(core_clk),
    .rst_n(rst_n),
    .tick(tick),
    .run(cs && !in_por && (txd == st_reg.tx_prev)), // [R10]
    .expired(settled)
  );

  lintc_timer #(.W(lintc_pkg::CNT_W), .LIMIT(DOM_TIMEOUT_TICKS)) u_dominant (
    .clk(core_clk),
    .rst_n(rst_n),
    .tick(tick),
    .run(!lin_bus_line_in && !in_por), // [R20]
    .expired(dom_exp)
  );

  lintc_timer #(.W(lintc_pkg::CNT_W), .LIMIT(WAKE_LOW_TICKS)) u_wake (
    .clk(core_clk),
    .rst_n(rst_n),
    .tick(tick),
    .run((st_reg.mode == lintc_pkg::mode_power_down) && !lin_bus_line_in), // [R24]
    .expired(wake_exp)
  );

  // Self-restarting: expires for one cycle, then clears
  lintc_timer #(.W(lintc_pkg::CNT_W), .LIMIT(SAMPLE_TICKS)) u_sample (
    .clk(core_clk),
    .rst_n(rst_n),
    .tick(tick),
    .run(!samp_exp && !in_por), // [R11]
    .expired(samp_exp)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Fault and mode logic

  // Expiry flag still high in the cycle the bus rises
  assign lin_wake = wake_exp && !st_reg.bus_prev && lin_bus_line_in; // [R24]
  // Only the dominant-expected case is a fault; transmit high with bus low is reception
  assign mismatch = cs && (st_reg.mode == lintc_pkg::mode_operation) && settled &&
                    !txd && !st_reg.tx_prev && lin_bus_line_in; // [R9] [R10] [R12]
  assign int_fault = thermal_overload || dom_exp || mismatch; // [R16] [R18]
  assign go_op = regulator_output_ok && cs && st_reg.fault_smp && txd && !int_fault; // [R22] [R25]
  // An external low on the pin alone never sets the drive
  assign fault_drive = (cs && thermal_overload) || dom_exp || mismatch ||
                       (!cs && (st_reg.mode == lintc_pkg::mode_ready) && st_reg.wake_lin); // [R13] [R14] [R15] [R19]

  assign word = {st_reg.mode, st_reg.wake_lin, thermal_overload, dom_exp, mismatch};

  lintc_stream_if #(.W(lintc_pkg::STATUS_W)) push_if ();
  lintc_stream_if #(.W(lintc_pkg::STATUS_W)) pop_if ();

  assign push_if.valid = (word != st_reg.last_word);
  assign push_if.data = word;

  always_comb begin
    st_next = st_reg;
    st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + 1'b1; // [R26]
    st_next.tx_prev = txd;
    st_next.bus_prev = lin_bus_line_in;
    if (samp_exp) begin
      st_next.fault_smp = fault_tx_enable_in; // [R11]
    end
    if (push_if.valid && push_if.ready) begin
      st_next.last_word = word;
    end
    if (!battery_supply_ok) begin
      st_next.mode = lintc_pkg::mode_por;
    end else begin
      case (st_reg.mode)
        lintc_pkg::mode_por: begin
          st_next.mode = lintc_pkg::mode_ready;
          st_next.wake_lin = 1'b0;
        end
        lintc_pkg::mode_ready: begin
          if (cs && regulator_output_ok) begin
            st_next.mode = go_op ? lintc_pkg::mode_operation : lintc_pkg::mode_tx_off; // [R2]
          end
        end
        lintc_pkg::mode_operation: begin
          if (!cs) begin
            st_next.mode = lintc_pkg::mode_power_down; // [R23]
          end else if (!st_reg.fault_smp || int_fault || !regulator_output_ok) begin
            st_next.mode = lintc_pkg::mode_tx_off; // [R8] [R23] [R25]
          end
        end
        lintc_pkg::mode_tx_off: begin
          if (!cs) begin
            st_next.mode = lintc_pkg::mode_power_down;
          end else if (go_op) begin
            st_next.mode = lintc_pkg::mode_operation; // [R22]
          end
        end
        lintc_pkg::mode_power_down: begin
          if (cs) begin
            st_next.mode = lintc_pkg::mode_ready; // [R4]
            st_next.wake_lin = 1'b0;
          end else if (lin_wake) begin
            st_next.mode = lintc_pkg::mode_ready; // [R24]
            st_next.wake_lin = 1'b1;
          end
        end
        default: begin
          st_next.mode = lintc_pkg::mode_por;
        end
      endcase
    end
    st_next.lin_oe = (st_next.mode == lintc_pkg::mode_operation) && !txd &&
                     !dom_exp && !thermal_overload; // [R5] [R16] [R18]
    st_next.fault_oe = fault_drive; // [R12] [R13]
    st_next.pull_up = (st_next.mode == lintc_pkg::mode_operation) && !dom_exp; // [R19]
    st_next.reg_en = !in_por && (st_reg.mode != lintc_pkg::mode_power_down) &&
                     !thermal_overload; // [R16]
    st_next.rx = (rx_on && !dom_exp) ? lin_bus_line_in : 1'b1; // [R1] [R19]
    st_next.rst_out_n = regulator_output_ok && !in_por; // [R7]
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= lintc_pkg::STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status stream; a stalled reader loses intermediate words once the buffer is full, the latest state is kept

  lintc_buffer #(.W(lintc_pkg::STATUS_W), .DEPTH(lintc_pkg::BUF_DEPTH)) u_buffer (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_s(push_if),
    .out_s(pop_if)
  );

  assign status_valid = pop_if.valid;
  assign pop_if.ready = status_ready;
  assign status_data = pop_if.data;

  assign fault_tx_enable_out = 1'b0;
  assign fault_tx_enable_oe = st_reg.fault_oe;
  assign lin_bus_line_out = 1'b0;
  assign lin_bus_line_oe = st_reg.lin_oe;
  assign lin_pull_up_en = st_reg.pull_up;
  assign rx_data = st_reg.rx;
  assign reset_out_n = st_reg.rst_out_n;
  assign regulator_en = st_reg.reg_en;
  assign mode = st_reg.mode;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic rx_cause;
  logic rst_cause;
  logic in_op;
  logic wake_lin;
  logic [lintc_pkg::CNT_W-1:0] sample_gap;

  assign rx_cause = rx_on && !dom_exp;
  assign rst_cause = regulator_output_ok && !in_por;
  assign in_op = (st_reg.mode == lintc_pkg::mode_operation);
  assign wake_lin = st_reg.wake_lin;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_gap <= '0;
    end else if (samp_exp || in_por) begin
      sample_gap <= '0;
    end else begin
      sample_gap <= sample_gap + 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  rx_follow_a: assert property (rx_cause |=> rx_data == $past(lin_bus_line_in)) // [R1]
    else $error("rx does not follow bus");
  cs_low_mode_a: assert property (!cs && battery_supply_ok |=>
    !(in_op || mode == lintc_pkg::mode_tx_off)) // [R2]
    else $error("active mode with select low");
  float_off_a: assert property (select_floating |=> !lin_bus_line_oe) // [R3]
    else $error("driving with floating select");
  local_wake_a: assert property ((mode == lintc_pkg::mode_power_down) && cs &&
    battery_supply_ok |=> mode == lintc_pkg::mode_ready) // [R4]
    else $error("local wake missed");
  tx_drive_a: assert property (lin_bus_line_oe |-> $past(!txd) && in_op) // [R5]
    else $error("dominant without transmit low");
  tx_float_a: assert property (tx_floating |=> !lin_bus_line_oe) // [R6]
    else $error("driving with floating transmit");
  reset_out_a: assert property (##1 reset_out_n == $past(rst_cause)) // [R7]
    else $error("reset output wrong");
  fault_low_a: assert property (in_op && !st_reg.fault_smp |=> !in_op) // [R8]
    else $error("enable low kept operation");
  mismatch_flag_a: assert property (mismatch |=> fault_tx_enable_oe) // [R9]
    else $error("mismatch not reported");
  settle_wait_a: assert property ($changed(txd) |-> !mismatch ##1 !settled && !mismatch) // [R10]
    else $error("fault inside settling window");
  sample_rate_a: assert property (sample_gap < lintc_pkg::CNT_W'(lintc_pkg::SAMPLE_MAX_CYCLES)) // [R11]
    else $error("enable pin sampled too rarely");
  short_batt_a: assert property (cs && in_op && settled && $stable(txd) && !txd
    && lin_bus_line_in |=> fault_tx_enable_oe) // [R12]
    else $error("short to battery not flagged");
  thermal_fault_a: assert property (cs && thermal_overload |=> fault_tx_enable_oe) // [R13]
    else $error("thermal fault not flagged");
  ext_off_a: assert property (cs && !fault_tx_enable_in && !int_fault |=>
    !fault_tx_enable_oe) // [R14]
    else $error("external off reported as fault");
  wake_src_a: assert property (!cs && (mode == lintc_pkg::mode_ready) |=>
    fault_tx_enable_oe == $past(wake_lin)) // [R15]
    else $error("wake source not shown");
  thermal_off_a: assert property (thermal_overload |=> !lin_bus_line_oe && !regulator_en) // [R16]
    else $error("thermal shutdown ignored");
  dom_off_a: assert property (dom_exp |=> !lin_bus_line_oe ##1 !in_op || !dom_exp) // [R18]
    else $error("timeout left transmitter on");
  dom_effects_a: assert property (dom_exp |=> rx_data && fault_tx_enable_oe &&
    !lin_pull_up_en) // [R19]
    else $error("timeout effects incomplete");
  dom_restart_a: assert property (lin_bus_line_in || in_por |=> !dom_exp) // [R20]
    else $error("timeout timer not restarted");
  enter_op_a: assert property ($rose(in_op) |-> $past(go_op)) // [R22]
    else $error("operation entered without conditions");
  op_exit_a: assert property (in_op && !cs && battery_supply_ok |=>
    mode == lintc_pkg::mode_power_down) // [R23]
    else $error("select low did not power down");
  lin_wake_a: assert property (lin_wake && battery_supply_ok |=>
    (mode == lintc_pkg::mode_ready) && wake_lin) // [R24]
    else $error("remote wake missed");
  int_fault_a: assert property (int_fault && battery_supply_ok |=> !in_op) // [R25]
    else $error("operation during internal fault");
  por_clear_a: assert property (in_por |=> !dom_exp && !settled) // [R26]
    else $error("timers not cleared in reset mode");

  op_seen_c: cover property ($rose(in_op));
  timeout_seen_c: cover property (dom_exp);
  lin_wake_seen_c: cover property (lin_wake);
  buffer_full_c: cover property (push_if.valid && !push_if.ready);

endmodule // lintc_top

// ### logic/lintc_pkg.sv
package lintc_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int CNT_W = 16;

  // Free-running timebase, one tick per microsecond
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

  // Bus dominant timeout, longest time, rounded down
  localparam int DOM_TIMEOUT_MS = 20;
  localparam int DOM_TIMEOUT_TICKS = (DOM_TIMEOUT_MS * 1000 * 1000) / TICK_NS;

  // Mismatch settling after a transmit edge, least time, rounded up
  localparam int SETTLE_US = 25;
  localparam int SETTLE_TICKS = (SETTLE_US * 1000 + TICK_NS - 1) / TICK_NS;

  // Least low time on the bus for a remote wake, rounded up
  localparam int WAKE_LOW_US = 80;
  localparam int WAKE_LOW_TICKS = (WAKE_LOW_US * 1000 + TICK_NS - 1) / TICK_NS;

  // Enable pin sampling interval; must stay below the ceiling
  localparam int SAMPLE_US = 5;
  localparam int SAMPLE_TICKS = (SAMPLE_US * 1000) / TICK_NS;
  localparam int SAMPLE_MAX_US = 10;
  localparam int SAMPLE_MAX_CYCLES = (SAMPLE_MAX_US * 1000) / CLK_PERIOD_NS;

  localparam int BUF_DEPTH = 2;

  // Status word layout
  localparam int STATUS_W = 7;
  localparam int ST_MISMATCH_BIT = 0;
  localparam int ST_TIMEOUT_BIT = 1;
  localparam int ST_THERMAL_BIT = 2;
  localparam int ST_WAKE_LIN_BIT = 3;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_MODE_MSB = 6;

  typedef enum logic [2:0] {
    mode_por,
    mode_ready,
    mode_operation,
    mode_tx_off,
    mode_power_down
  } lintc_mode_t;

  typedef struct packed {
    lintc_mode_t mode;
    logic [CNT_W-1:0] tick_cnt;
    logic tx_prev;
    logic bus_prev;
    logic fault_smp;
    logic wake_lin;
    logic lin_oe;
    logic fault_oe;
    logic pull_up;
    logic reg_en;
    logic rx;
    logic rst_out_n;
    logic [STATUS_W-1:0] last_word;
  } lintc_state_t;

  localparam lintc_state_t STATE_RESET = '{
    mode: mode_por,
    tick_cnt: 16'h0000,
    tx_prev: 1'b1,
    bus_prev: 1'b1,
    fault_smp: 1'b0,
    wake_lin: 1'b0,
    lin_oe: 1'b0,
    fault_oe: 1'b0,
    pull_up: 1'b0,
    reg_en: 1'b0,
    rx: 1'b1,
    rst_out_n: 1'b0,
    last_word: 7'h00
  };

endpackage

// ### logic/lintc_stream_if.sv
`timescale 1ns/1ps
interface lintc_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // lintc_stream_if

// ### logic/lintc_timer.sv
`timescale 1ns/1ps
// Saturating tick counter; cleared whenever run is low
module lintc_timer #(
  parameter int W = 16,
  parameter int LIMIT = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic run,
  output logic expired
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic exp;
  } lintc_timer_state_t;

  lintc_timer_state_t st_reg;
  lintc_timer_state_t st_next;
  logic [W-1:0] inc;

  always_comb begin
    inc = st_reg.cnt + 1'b1;
    st_next = st_reg;
    if (!run) begin
      st_next.cnt = '0;
      st_next.exp = 1'b0;
    end else if (tick && !st_reg.exp) begin
      st_next.cnt = inc;
      st_next.exp = (inc >= W'(LIMIT));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign expired = st_reg.exp;

endmodule // lintc_timer

// ### logic/lintc_buffer.sv
`timescale 1ns/1ps
// Small FIFO; pointers wrap at DEPTH - 1, so DEPTH need not be a power of two
module lintc_buffer #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  lintc_stream_if.snk in_s,
  lintc_stream_if.src out_s
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } lintc_buf_state_t;

  lintc_buf_state_t st_reg;
  lintc_buf_state_t st_next;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] lintc_next_ptr(input logic [AW-1:0] p);
    lintc_next_ptr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign in_s.ready = (st_reg.cnt != (AW + 1)'(DEPTH));
  assign out_s.valid = (st_reg.cnt != '0);
  assign out_s.data = st_reg.mem[st_reg.rp];

  always_comb begin
    push = in_s.valid && in_s.ready;
    pop = out_s.valid && out_s.ready;
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_s.data;
      st_next.wp = lintc_next_ptr(st_reg.wp);
    end
    if (pop) begin
      st_next.rp = lintc_next_ptr(st_reg.rp);
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule // lintc_buffer

// ### verif/lintc_bus_model.sv
`timescale 1ns/1ps
// Far side: LIN wire with pull-up, other nodes on it, host side of the fault wire
module lintc_bus_model (
  input wire logic lin_oe,
  input wire logic fault_oe,
  input wire logic ext_dom,
  input wire logic short_bat,
  input wire logic host_low,
  output logic lin_level,
  output logic fault_level
);
  // A short to battery beats every dominant driver
  assign lin_level = short_bat | ~(lin_oe | ext_dom);
  // Open drain with pull-up; a host low commands the transmitter off
  assign fault_level = ~(fault_oe | host_low);
endmodule // lintc_bus_model

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // Short counts keep the run small; expectations scale from them
  localparam int TC = 4;
  localparam int DT = 50;
  localparam int WL = 5;
  logic core_clk;
  logic reset_n;
  logic bat_ok, reg_ok, therm, sel, sel_fl, txd, tx_fl;
  logic ext_dom, short_bat, host_low, st_ready;
  logic f_in, f_out, f_oe, lin_in, lin_out, lin_oe, pu, rxd, rst_o_n, reg_en;
  logic st_valid;
  logic [lintc_pkg::STATUS_W-1:0] st_data;
  logic [lintc_pkg::STATUS_W-1:0] last_word;
  lintc_pkg::lintc_mode_t mode;
  int failures;
  int total_checks;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  lintc_top #(.TICK_CYCLES(TC), .DOM_TIMEOUT_TICKS(DT), .SETTLE_TICKS(3),
    .WAKE_LOW_TICKS(WL), .SAMPLE_TICKS(2)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .battery_supply_ok(bat_ok),
    .regulator_output_ok(reg_ok), .thermal_overload(therm), .select_local_wake(sel),
    .select_floating(sel_fl), .tx_data(txd), .tx_floating(tx_fl),
    .fault_tx_enable_in(f_in), .fault_tx_enable_out(f_out), .fault_tx_enable_oe(f_oe),
    .lin_bus_line_in(lin_in), .lin_bus_line_out(lin_out), .lin_bus_line_oe(lin_oe),
    .lin_pull_up_en(pu), .rx_data(rxd), .reset_out_n(rst_o_n), .regulator_en(reg_en),
    .mode(mode), .status_valid(st_valid), .status_ready(st_ready), .status_data(st_data));
  lintc_bus_model far (.lin_oe(lin_oe), .fault_oe(f_oe), .ext_dom(ext_dom),
    .short_bat(short_bat), .host_low(host_low), .lin_level(lin_in), .fault_level(f_in));
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wait_mode(input lintc_pkg::lintc_mode_t m, input int lim);
    @(negedge core_clk);
    for (int i = 0; i < lim && mode !== m; i++) @(negedge core_clk);
    if (mode !== m) begin
      failures++;
      complete_run();
    end
  endtask
  // Polls the fault drive (0) or the receive output (1)
  task automatic wait_sig(input int w, input logic v, input int lim);
    logic s;
    @(negedge core_clk);
    for (int i = 0; i < lim; i++) begin
      s = (w == 0) ? f_oe : rxd;
      if (s === v) return;
      @(negedge core_clk);
    end
    failures++;
    complete_run();
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    total_checks = 0;
    reset_n = 1'b0;
    bat_ok = 1'b1;
    reg_ok = 1'b1;
    therm = 1'b0;
    sel = 1'b0;
    sel_fl = 1'b0;
    txd = 1'b1;
    tx_fl = 1'b0;
    ext_dom = 1'b0;
    short_bat = 1'b0;
    host_low = 1'b0;
    st_ready = 1'b0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_mode(lintc_pkg::mode_ready, 20);
    // Reset output and fault drive settle one cycle after entering ready
    cyc(1);
    check(rst_o_n, 1'b1);
    check(f_oe, 1'b0);
    check(rxd, 1'b1);
    check({f_out, lin_out, reg_en}, 3'h1);
    @(posedge core_clk);
    sel <= 1'b1;
    sel_fl <= 1'b1;
    cyc(30);
    check(mode, lintc_pkg::mode_ready);
    check(lin_oe, 1'b0);
    @(posedge core_clk);
    sel_fl <= 1'b0;
    wait_mode(lintc_pkg::mode_operation, 40);
    check(pu, 1'b1);
    @(posedge core_clk);
    txd <= 1'b0;
    cyc(3);
    check(lin_oe, 1'b1);
    check(rxd, 1'b0);
    @(posedge core_clk);
    txd <= 1'b1;
    cyc(3);
    check({lin_oe, rxd}, 2'h1);
    @(posedge core_clk);
    txd <= 1'b0;
    tx_fl <= 1'b1;
    cyc(3);
    check({lin_oe, lin_in}, 2'h1);
    @(posedge core_clk);
    txd <= 1'b1;
    tx_fl <= 1'b0;
    host_low <= 1'b1;
    wait_mode(lintc_pkg::mode_tx_off, 30);
    cyc(20);
    check({f_oe, lin_oe}, 2'h0);
    @(posedge core_clk);
    host_low <= 1'b0;
    wait_mode(lintc_pkg::mode_operation, 40);
    // Bus stuck at battery while transmitting dominant
    @(posedge core_clk);
    short_bat <= 1'b1;
    txd <= 1'b0;
    cyc(2 * TC);
    check(f_oe, 1'b0);
    wait_sig(0, 1'b1, 40);
    check(rxd, 1'b1);
    wait_mode(lintc_pkg::mode_tx_off, 30);
    @(posedge core_clk);
    short_bat <= 1'b0;
    txd <= 1'b1;
    wait_mode(lintc_pkg::mode_operation, 60);
    @(posedge core_clk);
    therm <= 1'b1;
    txd <= 1'b0;
    wait_sig(0, 1'b1, 10);
    wait_mode(lintc_pkg::mode_tx_off, 30);
    check({reg_en, lin_oe, rxd}, 3'h1);
    @(posedge core_clk);
    therm <= 1'b0;
    txd <= 1'b1;
    wait_mode(lintc_pkg::mode_operation, 60);
    // Two dominant stretches split by recessive must not expire
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      ext_dom <= 1'b1;
      cyc(DT * TC * 3 / 4);
      @(posedge core_clk);
      ext_dom <= 1'b0;
      cyc(2);
    end
    check(f_oe, 1'b0);
    @(posedge core_clk);
    ext_dom <= 1'b1;
    cyc(DT * TC - 40);
    check(rxd, 1'b0);
    wait_sig(1, 1'b1, 100);
    check({f_oe, pu, lin_oe}, 3'h4);
    @(posedge core_clk);
    ext_dom <= 1'b0;
    wait_sig(0, 1'b0, 30);
    wait_mode(lintc_pkg::mode_operation, 60);
    @(posedge core_clk);
    reg_ok <= 1'b0;
    cyc(3);
    check(rst_o_n, 1'b0);
    wait_mode(lintc_pkg::mode_tx_off, 30);
    @(posedge core_clk);
    reg_ok <= 1'b1;
    cyc(3);
    check(rst_o_n, 1'b1);
    wait_mode(lintc_pkg::mode_operation, 60);
    @(posedge core_clk);
    sel <= 1'b0;
    wait_mode(lintc_pkg::mode_power_down, 10);
    check(pu, 1'b0);
    // A low shorter than the wake time is ignored, a longer one wakes
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      ext_dom <= 1'b1;
      cyc(k == 0 ? 2 * TC : WL * TC + 8);
      @(posedge core_clk);
      ext_dom <= 1'b0;
      cyc(10);
    end
    check(mode, lintc_pkg::mode_ready);
    check(f_oe, 1'b1);
    @(posedge core_clk);
    sel <= 1'b1;
    wait_mode(lintc_pkg::mode_operation, 60);
    @(posedge core_clk);
    sel <= 1'b0;
    wait_mode(lintc_pkg::mode_power_down, 10);
    @(posedge core_clk);
    sel <= 1'b1;
    wait_mode(lintc_pkg::mode_operation, 60);
    @(posedge core_clk);
    bat_ok <= 1'b0;
    cyc(3);
    check({mode, rst_o_n}, {lintc_pkg::mode_por, 1'b0});
    @(posedge core_clk);
    bat_ok <= 1'b1;
    sel <= 1'b0;
    wait_mode(lintc_pkg::mode_ready, 10);
    // Fault drive follows the ready state one cycle late
    cyc(2);
    check(f_oe, 1'b0);
    // Status words piled up while the reader stalled; drain them
    check(st_valid, 1'b1);
    @(posedge core_clk);
    st_ready <= 1'b1;
    last_word = '0;
    @(negedge core_clk);
    for (int i = 0; i < 10 && st_valid === 1'b1; i++) begin
      last_word = st_data;
      @(negedge core_clk);
    end
    check(st_valid, 1'b0);
    check(last_word[lintc_pkg::ST_MODE_MSB:lintc_pkg::ST_MODE_LSB], mode);
    complete_run();
  end
endmodule // tb_top
